// >>> src/ssl_port.sv
// Purpose: serial load port with latches, counters and lock monitor
// Assumes: sclk_i, serial_in_i, load_strobe_i and pins are asynchronous
// Notes: registers reached over a plain strobe port
// Overview of operation
// - each rising serial clock edge shifts serial_in into a 24-bit register
// - rising load strobe copies the word into the latch chosen by select bits
// - output becomes active only after reference, feedback and init writes
// - counter reset holds counters at load point, charge pump high impedance
// - counter reset never starts synchronous power-down; init pulse may
// - releasing counter reset restarts both counters together
// - monitor output selects among internal signals including lock indication
// - select bits: 00 reference, 01 feedback, 10 function, 11 init latch
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module ssl_port
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic load_strobe_i,
  input wire logic chip_enable_i,
  input wire logic ref_in_i,
  input wire logic rf_in_i,
  input wire logic [ssl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ssl_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ssl_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  output logic monitor_out_o,
  output logic cp_up_o,
  output logic cp_dn_o,
  output logic cp_oe_o
);
  typedef enum logic [1:0] {SSL_RUN = 2'b00, SSL_HOLD = 2'b01, SSL_SETTLE = 2'b11}
    ssl_cnt_state_t;

  function automatic logic ssl_mon_pick(input logic [2:0] sel, input logic lock,
    input logic rt, input logic ft, input logic act, input logic crst);
    logic r;
    r = 1'b0;
    case (sel)
      ssl_pkg::MON_LOCK: r = lock;
      ssl_pkg::MON_REF: r = rt;
      ssl_pkg::MON_FB: r = ft;
      ssl_pkg::MON_HIGH: r = 1'b1;
      ssl_pkg::MON_ACTIVE: r = act;
      ssl_pkg::MON_CRST: r = crst;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // pin synchronisers
  logic [ssl_pkg::SYNC_W-1:0] pins_s;
  logic sclk_s, serial_in_s, le_s, ce_s, ref_s, rf_s;
  ssl_sync u_sync
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({rf_in_i, ref_in_i, chip_enable_i, !load_strobe_i, serial_in_i, sclk_i}),
    .sync_o(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign serial_in_s = pins_s[1];
  // strobe idles high: carried inverted so a reset synchroniser reads idle
  assign le_s = !pins_s[2];
  assign ce_s = pins_s[3];
  assign ref_s = pins_s[4];
  assign rf_s = pins_s[5];

  // serial shift group
  logic sclk_prev_q, sclk_prev_d, le_prev_q, le_prev_d;
  logic ref_prev_q, ref_prev_d, rf_prev_q, rf_prev_d;
  logic [ssl_pkg::WORD_W-1:0] shift_q, shift_d;
  logic load_now;
  logic [1:0] load_sel;
  logic ref_edge, rf_edge;
  always_comb
  begin
    sclk_prev_d = sclk_s;
    le_prev_d = le_s;
    ref_prev_d = ref_s;
    rf_prev_d = rf_s;
    shift_d = shift_q;
    if (sclk_s && !sclk_prev_q)
      shift_d = {shift_q[ssl_pkg::WORD_W-2:0], serial_in_s};
    load_now = le_s && !le_prev_q;
    load_sel = shift_q[ssl_pkg::SEL_W-1:0];
    ref_edge = ref_s && !ref_prev_q;
    rf_edge = rf_s && !rf_prev_q;
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_prev_q <= 1'b0;
      le_prev_q <= 1'b1;
      ref_prev_q <= 1'b0;
      rf_prev_q <= 1'b0;
      shift_q <= 24'h0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      le_prev_q <= le_prev_d;
      ref_prev_q <= ref_prev_d;
      rf_prev_q <= rf_prev_d;
      shift_q <= shift_d;
    end
  end

  // control group: decoded latch fields and start-up flags
  logic [ssl_pkg::REF_W-1:0] ref_div_q, ref_div_d;
  logic [ssl_pkg::N_W-1:0] n_div_q, n_div_d;
  logic crst_q, crst_d, pd1_q, pd1_d, pd2_q, pd2_d, pol_q, pol_d, tri_q, tri_d;
  logic [2:0] mux_q, mux_d;
  logic ref_w_q, ref_w_d, fb_w_q, fb_w_d, init_w_q, init_w_d;
  logic arm_q, arm_d, pulse_q, pulse_d;
  logic sync_pend_q, sync_pend_d, sync_pd_q, sync_pd_d;
  logic active, async_pd, power_down, cp_event;
  always_comb
  begin
    ref_div_d = ref_div_q;
    n_div_d = n_div_q;
    crst_d = crst_q;
    pd1_d = pd1_q;
    pd2_d = pd2_q;
    pol_d = pol_q;
    tri_d = tri_q;
    mux_d = mux_q;
    ref_w_d = ref_w_q;
    fb_w_d = fb_w_q;
    init_w_d = init_w_q;
    arm_d = arm_q;
    pulse_d = 1'b0;
    sync_pend_d = sync_pend_q;
    sync_pd_d = sync_pd_q;
    if (load_now)
    begin
      case (load_sel)
        ssl_pkg::SEL_REF:
        begin
          ref_div_d = shift_q[ssl_pkg::REF_LSB +: ssl_pkg::REF_W];
          ref_w_d = 1'b1;
        end
        ssl_pkg::SEL_FB:
        begin
          n_div_d = ssl_pkg::N_W'({shift_q[ssl_pkg::B_LSB +: ssl_pkg::B_W],
            shift_q[ssl_pkg::A_LSB +: ssl_pkg::A_W]});
          fb_w_d = 1'b1;
          if (arm_q)
          begin
            pulse_d = 1'b1;
            arm_d = 1'b0;
          end
        end
        default:
        begin
          crst_d = shift_q[ssl_pkg::CNT_RST_BIT];
          pd1_d = shift_q[ssl_pkg::PD1_BIT];
          pd2_d = shift_q[ssl_pkg::PD2_BIT];
          pol_d = shift_q[ssl_pkg::POL_BIT];
          tri_d = shift_q[ssl_pkg::CP_TRI_BIT];
          mux_d = shift_q[ssl_pkg::MUX_LSB +: ssl_pkg::MUX_W];
          if (load_sel == ssl_pkg::SEL_INIT)
          begin
            init_w_d = 1'b1;
            pulse_d = 1'b1;
            arm_d = 1'b1;
            if (shift_q[ssl_pkg::PD1_BIT] && shift_q[ssl_pkg::PD2_BIT])
              sync_pend_d = 1'b1;
          end
        end
      endcase
    end
    if (!pd1_d || !pd2_d)
    begin
      sync_pend_d = 1'b0;
      sync_pd_d = 1'b0;
    end
    else if (sync_pend_q && cp_event)
    begin
      sync_pend_d = 1'b0;
      sync_pd_d = 1'b1;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ref_div_q <= 14'h0;
      n_div_q <= 18'h0;
      crst_q <= 1'b0;
      pd1_q <= 1'b0;
      pd2_q <= 1'b0;
      pol_q <= 1'b0;
      tri_q <= 1'b0;
      mux_q <= 3'h0;
      ref_w_q <= 1'b0;
      fb_w_q <= 1'b0;
      init_w_q <= 1'b0;
      arm_q <= 1'b0;
      pulse_q <= 1'b0;
      sync_pend_q <= 1'b0;
      sync_pd_q <= 1'b0;
    end
    else
    begin
      ref_div_q <= ref_div_d;
      n_div_q <= n_div_d;
      crst_q <= crst_d;
      pd1_q <= pd1_d;
      pd2_q <= pd2_d;
      pol_q <= pol_d;
      tri_q <= tri_d;
      mux_q <= mux_d;
      ref_w_q <= ref_w_d;
      fb_w_q <= fb_w_d;
      init_w_q <= init_w_d;
      arm_q <= arm_d;
      pulse_q <= pulse_d;
      sync_pend_q <= sync_pend_d;
      sync_pd_q <= sync_pd_d;
    end
  end
  assign active = ref_w_q && fb_w_q && init_w_q;
  assign async_pd = !ce_s || (pd1_q && !pd2_q);
  assign power_down = async_pd || sync_pd_q;

  // counter group
  ssl_cnt_state_t cst_q, cst_d;
  logic [ssl_pkg::REF_W-1:0] rcnt_q, rcnt_d;
  logic [ssl_pkg::N_W+ssl_pkg::PRESCALE_SHIFT-1:0] fcnt_q, fcnt_d;
  logic [ssl_pkg::SETTLE_W-1:0] settle_q, settle_d;
  logic rtick_q, rtick_d, ftick_q, ftick_d;
  logic hold_req;
  logic ce_prev_q;
  logic [ssl_pkg::N_W+ssl_pkg::PRESCALE_SHIFT-1:0] n_full;
  assign n_full = {n_div_q[ssl_pkg::N_W-1:ssl_pkg::A_W], {ssl_pkg::PRESCALE_SHIFT{1'b0}}}
    + {{ssl_pkg::N_W{1'b0}}, n_div_q[ssl_pkg::A_W-1:0]};
  assign hold_req = crst_q || power_down || pulse_q || !active;
  assign cp_event = rtick_q || ftick_q;
  always_comb
  begin
    cst_d = cst_q;
    rcnt_d = rcnt_q;
    fcnt_d = fcnt_q;
    settle_d = settle_q;
    rtick_d = 1'b0;
    ftick_d = 1'b0;
    case (cst_q)
      SSL_RUN:
      begin
        if (hold_req)
          cst_d = SSL_HOLD;
        if (ref_edge)
        begin
          if (rcnt_q <= 14'h1)
          begin
            rcnt_d = ref_div_q;
            rtick_d = 1'b1;
          end
          else
            rcnt_d = rcnt_q - 14'h1;
        end
        if (rf_edge)
        begin
          if (fcnt_q <= 23'h1)
          begin
            fcnt_d = n_full;
            ftick_d = 1'b1;
          end
          else
            fcnt_d = fcnt_q - 23'h1;
        end
      end
      SSL_HOLD:
      begin
        rcnt_d = ref_div_q;
        fcnt_d = n_full;
        settle_d = ssl_pkg::SETTLE_W'(ssl_pkg::SETTLE_CYC);
        if (!hold_req)
          cst_d = async_pd ? SSL_HOLD : SSL_RUN;
        if (!hold_req && !ce_s)
          cst_d = SSL_HOLD;
        if (!hold_req && ce_s && settle_q != 8'h0 && !ce_prev_q)
          cst_d = SSL_SETTLE;
      end
      SSL_SETTLE:
      begin
        rcnt_d = ref_div_q;
        fcnt_d = n_full;
        if (hold_req)
          cst_d = SSL_HOLD;
        else if (settle_q == 8'h0)
          cst_d = SSL_RUN;
        else
          settle_d = settle_q - 8'h1;
      end
      default: cst_d = SSL_HOLD;
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cst_q <= SSL_HOLD;
      rcnt_q <= 14'h0;
      fcnt_q <= 23'h0;
      settle_q <= 8'h0;
      rtick_q <= 1'b0;
      ftick_q <= 1'b0;
      ce_prev_q <= 1'b0;
    end
    else
    begin
      cst_q <= cst_d;
      rcnt_q <= rcnt_d;
      fcnt_q <= fcnt_d;
      settle_q <= settle_d;
      rtick_q <= rtick_d;
      ftick_q <= ftick_d;
      ce_prev_q <= ce_s;
    end
  end

  // phase detector and lock group
  logic up_q, up_d, dn_q, dn_d, lock_q, lock_d;
  logic [ssl_pkg::ERR_W-1:0] err_q, err_d;
  logic [ssl_pkg::STREAK_W-1:0] streak_q, streak_d;
  logic run;
  assign run = (cst_q == SSL_RUN);
  always_comb
  begin
    up_d = up_q || rtick_q;
    dn_d = dn_q || ftick_q;
    err_d = err_q;
    streak_d = streak_q;
    if (up_q ^ dn_q)
      err_d = (err_q == 8'hff) ? err_q : err_q + 8'h1;
    if (up_d && dn_d)
    begin
      up_d = 1'b0;
      dn_d = 1'b0;
      err_d = 8'h0;
      if (err_q < ssl_pkg::ERR_W'(ssl_pkg::LOCK_WIN))
        streak_d = (streak_q == 2'h3) ? streak_q : streak_q + 2'h1;
      else
        streak_d = 2'h0;
    end
    lock_d = (streak_d >= ssl_pkg::STREAK_W'(ssl_pkg::LOCK_CNT));
    if (!run)
    begin
      up_d = 1'b0;
      dn_d = 1'b0;
      err_d = 8'h0;
      streak_d = 2'h0;
      lock_d = 1'b0;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      err_q <= 8'h0;
      streak_q <= 2'h0;
      lock_q <= 1'b0;
    end
    else
    begin
      up_q <= up_d;
      dn_q <= dn_d;
      err_q <= err_d;
      streak_q <= streak_d;
      lock_q <= lock_d;
    end
  end

  // register bus and interrupt group
  logic [ssl_pkg::IRQ_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  logic lock_prev_q, act_prev_q, irq_d;
  logic [ssl_pkg::DATA_W-1:0] bypass;
  logic rd_latch;
  assign ev[ssl_pkg::EV_WORD] = load_now;
  assign ev[ssl_pkg::EV_LOCK] = lock_q && !lock_prev_q;
  assign ev[ssl_pkg::EV_UNLOCK] = !lock_q && lock_prev_q;
  assign ev[ssl_pkg::EV_ACTIVE] = active && !act_prev_q;
  assign rd_latch = (addr_i & ssl_pkg::ADDR_LATCH_MASK) == ssl_pkg::ADDR_LATCH0;
  always_comb
  begin
    status_d = status_q;
    mask_d = mask_q;
    if (wr_i && addr_i == ssl_pkg::ADDR_STATUS)
      status_d = status_q & ~wdata_i[ssl_pkg::IRQ_W-1:0];
    if (wr_i && addr_i == ssl_pkg::ADDR_MASK)
      mask_d = wdata_i[ssl_pkg::IRQ_W-1:0];
    status_d = status_d | ev;
    irq_d = |(status_d & mask_d);
    case (addr_i)
      ssl_pkg::ADDR_STATUS: bypass = {28'h0, status_q};
      ssl_pkg::ADDR_MASK: bypass = {28'h0, mask_q};
      ssl_pkg::ADDR_STATE: bypass = {24'h0, init_w_q, fb_w_q, ref_w_q, active,
        lock_q, power_down, cst_q};
      default: bypass = 32'h0;
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_q <= 4'h0;
      mask_q <= ssl_pkg::MASK_RESET;
      lock_prev_q <= 1'b0;
      act_prev_q <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q <= mask_d;
      lock_prev_q <= lock_q;
      act_prev_q <= active;
      irq_o <= irq_d;
    end
  end

  ssl_latch_mem u_mem
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(load_now),
    .waddr_i(load_sel),
    .wdata_i(shift_q),
    .rd_i(rd_i),
    .rd_latch_i(rd_latch),
    .raddr_i(addr_i[3:2]),
    .bypass_i(bypass),
    .rdata_o(rdata_o)
  );

  // pin output group
  logic mon_d, cpu_d, cpd_d, cpoe_d;
  always_comb
  begin
    mon_d = ssl_mon_pick(mux_q, lock_q, rtick_q, ftick_q, active, crst_q);
    cpu_d = pol_q ? up_q : dn_q;
    cpd_d = pol_q ? dn_q : up_q;
    cpoe_d = run && !tri_q && !crst_q && !power_down;
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      monitor_out_o <= 1'b0;
      cp_up_o <= 1'b0;
      cp_dn_o <= 1'b0;
      cp_oe_o <= 1'b0;
    end
    else
    begin
      monitor_out_o <= mon_d;
      cp_up_o <= cpu_d;
      cp_dn_o <= cpd_d;
      cp_oe_o <= cpoe_d;
    end
  end
endmodule

// >>> src/ssl_pkg.sv
// Purpose: constants shared by the serial load port design
// Assumes: 200 MHz system clock
// Notes: latch words are 24 bits, two select bits at the bottom
package ssl_pkg;
  localparam int MCLK_MHZ = 200;
  localparam int WORD_W = 24;
  localparam int SEL_W = 2;
  // latch select codes
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // reference latch fields
  localparam int REF_LSB = 2;
  localparam int REF_W = 14;
  // feedback latch fields
  localparam int A_LSB = 2;
  localparam int A_W = 5;
  localparam int B_LSB = 7;
  localparam int B_W = 13;
  localparam int N_W = 18;
  localparam int PRESCALE_SHIFT = 5;
  // function latch fields
  localparam int CNT_RST_BIT = 2;
  localparam int PD1_BIT = 3;
  localparam int MUX_LSB = 4;
  localparam int MUX_W = 3;
  localparam int POL_BIT = 7;
  localparam int CP_TRI_BIT = 8;
  localparam int PD2_BIT = 19;
  // monitor output selections
  localparam logic [2:0] MON_LOW = 3'h0;
  localparam logic [2:0] MON_LOCK = 3'h1;
  localparam logic [2:0] MON_REF = 3'h2;
  localparam logic [2:0] MON_FB = 3'h3;
  localparam logic [2:0] MON_HIGH = 3'h4;
  localparam logic [2:0] MON_ACTIVE = 3'h5;
  localparam logic [2:0] MON_CRST = 3'h6;
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_LATCH0 = 8'h10;
  localparam logic [7:0] ADDR_LATCH_MASK = 8'hf0;
  localparam int IRQ_W = 4;
  localparam int EV_WORD = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_UNLOCK = 2;
  localparam int EV_ACTIVE = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // timing
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * MCLK_MHZ) / 1000;
  localparam int SETTLE_W = 8;
  localparam int LOCK_WIN = 4;
  localparam int LOCK_CNT = 3;
  localparam int ERR_W = 8;
  localparam int STREAK_W = 2;
  localparam int SYNC_W = 6;
endpackage

// >>> src/ssl_sync.sv
// Purpose: two-stage synchronisers for the pin inputs
// Assumes: inputs are asynchronous to mclk_i
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module ssl_sync
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [ssl_pkg::SYNC_W-1:0] async_i,
  output logic [ssl_pkg::SYNC_W-1:0] sync_o
);
  logic [ssl_pkg::SYNC_W-1:0] meta_q;
  genvar g;
  generate
    for (g = 0; g < ssl_pkg::SYNC_W; g = g + 1)
    begin : g_bit
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule

// >>> src/ssl_latch_mem.sv
// Purpose: four latch words and the registered read data of the bus
// Assumes: one write port, one read port
// Notes: non-latch reads pass the supplied word through the same register
`timescale 1ns/1ps
module ssl_latch_mem
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] waddr_i,
  input wire logic [ssl_pkg::WORD_W-1:0] wdata_i,
  input wire logic rd_i,
  input wire logic rd_latch_i,
  input wire logic [1:0] raddr_i,
  input wire logic [ssl_pkg::DATA_W-1:0] bypass_i,
  output logic [ssl_pkg::DATA_W-1:0] rdata_o
);
  logic [ssl_pkg::WORD_W-1:0] mem_q [4];
  logic [ssl_pkg::DATA_W-1:0] rdata_d;
  always_comb
  begin
    rdata_d = 32'h0;
    if (rd_i)
    begin
      if (rd_latch_i)
        rdata_d = {8'h0, mem_q[raddr_i]};
      else
        rdata_d = bypass_i;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 32'h0;
      for (int i = 0; i < 4; i++)
        mem_q[i] <= 24'h0;
    end
    else
    begin
      rdata_o <= rdata_d;
      if (wr_i)
        mem_q[waddr_i] <= wdata_i;
    end
  end
endmodule

// >>> verif/ssl_host_model.sv
// Purpose: host serial master that loads 24-bit words into the port
// Assumes: 125 ns serial clock, idle low between frames
// Notes: data changes on falling edge; released data line shows inverse of last bit
`timescale 1ns/1ps
module ssl_host_model
(
  output logic sclk_o,
  output logic serial_in_o,
  output logic strobe_o
);
  initial
  begin
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
    strobe_o = 1'b1;
  end
  // three bytes msb first, strobe raised only when latch is set
  task automatic send(input logic [23:0] word, input logic latch);
    #1 strobe_o = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      serial_in_o = word[i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    serial_in_o = ~word[0];
    #62.5 strobe_o = latch;
    #62.5;
  endtask
endmodule

// >>> verif/ssl_port_props.sv
// Purpose: concurrent checks on the serial load port pins and bus
// Assumes: single mclk_i domain, async active-high reset
// Notes: strobe rises counted to guard output activation
`timescale 1ns/1ps
module ssl_port_props
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_strobe_i,
  input wire logic chip_enable_i,
  input wire logic [ssl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ssl_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ssl_pkg::DATA_W-1:0] rdata_o,
  input wire logic irq_o,
  input wire logic cp_oe_o
);
  logic [1:0] nld_q, nld_d;
  logic le_q;
  always_comb
  begin
    nld_d = nld_q;
    if (load_strobe_i && !le_q && nld_q != 2'h3)
      nld_d = nld_q + 2'h1;
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nld_q <= 2'h0;
      le_q <= 1'b1;
    end
    else
    begin
      nld_q <= nld_d;
      le_q <= load_strobe_i;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_mask_wr_rd;
    wr_i && addr_i == ssl_pkg::ADDR_MASK ##2 rd_i && addr_i == ssl_pkg::ADDR_MASK;
  endsequence
  sequence s_word_then_status;
    $rose(load_strobe_i) ##0
      (!wr_i throughout (##[8:200] (rd_i && addr_i == ssl_pkg::ADDR_STATUS)));
  endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'h0c |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_mask_readback: assert property (s_mask_wr_rd |=>
    {28'h0, rdata_o[3:0]} == ($past(wdata_i, 3) & 32'hf))
    else $error("mask readback differs from write");
  a_state_upper: assert property (rd_i && addr_i == ssl_pkg::ADDR_STATE |=> rdata_o[31:8] == 24'h0)
    else $error("state upper bits not zero");
  a_latch_word_width: assert property (rd_i && addr_i[7:4] == 4'h1
    |=> rdata_o[31:24] == 8'h0)
    else $error("latch word wider than 24 bits");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt dropped without a write");
  a_out_inactive: assert property (nld_q != 2'h3 |-> !cp_oe_o)
    else $error("charge pump driven before three loads");
  a_word_status: assert property (s_word_then_status |=> rdata_o[0])
    else $error("word latched event missing");
  a_pd_state: assert property ((!chip_enable_i)[*8]
    ##0 rd_i && addr_i == ssl_pkg::ADDR_STATE |=> rdata_o[2])
    else $error("power-down not reported");
  a_pd_pump_off: assert property ((!chip_enable_i)[*8] |-> !cp_oe_o)
    else $error("charge pump driven while powered down");
endmodule
bind ssl_port ssl_port_props u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .load_strobe_i(load_strobe_i), .chip_enable_i(chip_enable_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .cp_oe_o(cp_oe_o));

// >>> verif/testbench.sv
// Purpose: self-checking bench for the serial load port
// Assumes: 200 MHz mclk, host model loads words at 8 MHz
// Notes: reference and feedback inputs share one waveform so the loop locks
`timescale 1ns/1ps
module testbench;
  logic mclk_i, rst_i, ce, rd, wr, sclk, sdat, le, irq, mon, up, dn, oe;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rd_v, hi;
  logic [2:0] ph;
  int n_errors, tests_run, cyc;
  ssl_host_model host (.sclk_o(sclk), .serial_in_o(sdat), .strobe_o(le));
  ssl_port uut (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .serial_in_i(sdat),
    .load_strobe_i(le), .chip_enable_i(ce), .ref_in_i(ph[2]), .rf_in_i(ph[2]),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .monitor_out_o(mon), .cp_up_o(up), .cp_dn_o(dn), .cp_oe_o(oe));
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    ph <= ph + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] msk,
    input logic [31:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 rd_v = rdata;
    chk(nm, rd_v & msk, exp);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst_i = 1'b1;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    ph = 3'h0;
    cyc = 0;
    n_errors = 0;
    tests_run = 0;
    cycles(4);
    rst_i <= 1'b0;
    rchk("mask_reset", 8'h04, 32'hf, 32'h0);
    bus_wr(8'h04, 32'h1);
    rchk("mask_rb", 8'h04, 32'hffffffff, 32'h1);
    bus_wr(8'h0c, 32'hff);
    rchk("unmapped", 8'h0c, 32'hffffffff, 32'h0);
    chk("oe_idle", {31'h0, oe}, 32'h0);
    // reset bit with both power-down bits: hold, no power-down
    host.send(24'h08009e, 1'b1);
    cycles(12);
    rchk("func_latch", 8'h18, 32'hffffffff, 32'h08009e);
    rchk("state_hold", 8'h08, 32'h7, 32'h1);
    chk("oe_hold", {31'h0, oe}, 32'h0);
    rchk("status_word", 8'h00, 32'h1, 32'h1);
    chk("irq_set", {31'h0, irq}, 32'h1);
    bus_wr(8'h00, 32'h1);
    cycles(3);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    rchk("status_clr", 8'h00, 32'h1, 32'h0);
    // shifted word without strobe leaves latches alone
    host.send(24'hfffffe, 1'b0);
    rchk("no_strobe", 8'h18, 32'hffffffff, 32'h08009e);
    host.send(24'h000010, 1'b1);
    host.send(24'h000011, 1'b1);
    host.send(24'h000092, 1'b1);
    cycles(12);
    rchk("ref_latch", 8'h10, 32'hffffffff, 32'h10);
    rchk("fb_latch", 8'h14, 32'hffffffff, 32'h11);
    rchk("state_no_init", 8'h08, 32'h3, 32'h1);
    rchk("not_active", 8'h08, 32'hf0, 32'h60);
    host.send(24'h000093, 1'b1);
    cycles(1000);
    rchk("active_lock", 8'h08, 32'hff, 32'hf8);
    chk("mon_lock", {31'h0, mon}, 32'h1);
    chk("oe_run", {31'h0, oe}, 32'h1);
    chk("pump_quiet", {30'h0, up, dn}, 32'h0);
    rchk("status_ev", 8'h00, 32'ha, 32'ha);
    // counter reset while running, then released
    host.send(24'h000096, 1'b1);
    cycles(12);
    rchk("state_crst", 8'h08, 32'h7, 32'h1);
    chk("oe_crst", {31'h0, oe}, 32'h0);
    rchk("status_unlock", 8'h00, 32'h4, 32'h4);
    host.send(24'h000092, 1'b1);
    cycles(12);
    rchk("state_crst_off", 8'h08, 32'h3, 32'h0);
    chk("oe_crst_off", {31'h0, oe}, 32'h1);
    for (int m = 0; m < 8; m++)
    begin
      host.send(24'h000082 | {17'h0, m[2:0], 4'h0}, 1'b1);
      cycles(12);
      if (m != 2 && m != 3)
        chk("monitor", {31'h0, mon}, {31'h0, (m == 1 || m == 4 || m == 5)});
      else
      begin
        hi = 32'h0;
        repeat (64)
        begin
          @(posedge mclk_i);
          #1 hi = hi + {31'h0, mon};
        end
        chk("tick_count", hi, 32'h2);
      end
    end
    @(posedge mclk_i);
    ce <= 1'b0;
    host.send(24'h000024, 1'b1);
    cycles(12);
    rchk("ref_pd", 8'h10, 32'hffffffff, 32'h24);
    rchk("state_pd", 8'h08, 32'h4, 32'h4);
    chk("oe_pd", {31'h0, oe}, 32'h0);
    @(posedge mclk_i);
    ce <= 1'b1;
    cycles(10);
    rchk("state_settle", 8'h08, 32'h7, 32'h3);
    cycles(250);
    rchk("state_run", 8'h08, 32'h7, 32'h0);
    // init with both power-down bits waits for a pump event
    host.send(24'h08001b, 1'b1);
    cycles(100);
    rchk("state_sync_pd", 8'h08, 32'h7, 32'h5);
    chk("oe_sync_pd", {31'h0, oe}, 32'h0);
    tally_and_finish();
  end
endmodule
